// ### src/bdm_pkg.sv
package bdm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned OP_W     = 7;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned EFF_W    = 9;
  localparam int unsigned WB_ADR_W = 9;
  localparam int unsigned WB_ADR_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // locations inside one bank (7-bit operand field)
  localparam logic [OP_W-1:0] INDIRECT_OFS = 7'h00;
  localparam logic [OP_W-1:0] STATUS_OFS   = 7'h03;
  localparam logic [OP_W-1:0] POINTER_OFS  = 7'h04;
  localparam logic [OP_W-1:0] GPR_BASE     = 7'h20;
  localparam logic [OP_W-1:0] COMMON_LO    = 7'h70;

  // general-purpose bytes that fit in bank 0 between 20h and 7Fh
  localparam int unsigned BANK0_GPR_MAX = 96;

  ////////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int unsigned BANK_SEL_BIT = 5;
  localparam int unsigned IND_BANK_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [DATA_W-1:0] STATUS_RST  = 8'h00;
  localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    REG_NONE    = 3'b000,
    REG_STATUS  = 3'b001,
    REG_POINTER = 3'b010,
    REG_SFR     = 3'b011,
    REG_GPR     = 3'b100
  } bdm_region_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              strobe;
  } bdm_sfr_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              en;
  } bdm_sfr_rd_s;

endpackage : bdm_pkg

// ### src/bdm_data_memory.sv
// Behaviour
// - two banks chosen by bank select bit
// - first 32 locations per bank are special
// - general RAM 20h-7Fh (20h-6Fh on 80 bytes), A0h-BFh on large
// - bank 1 F0h-FFh aliases 70h-7Fh (not on 80 bytes)
// - bank 1 specials reached by bank or pointer
// - file size 80, 96 or 128 bytes
// - indirect port has no storage, uses pointer
// - indirect access reaches any bank via pointer
// - indirect read of indirect port gives 00h
// - indirect write of indirect port stores nothing
// - effective address is the pointer alone
// - indirect bank bit ignored, 256 locations only
`timescale 1ns/10ps

module bdm_data_memory #(
  parameter int unsigned GPR_BYTES  = 96,
  parameter bit          COMMON_RAM = 1'b1
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // classic wishbone slave, word per register
  input  wire logic                          wbCyc,
  input  wire logic                          wbStb,
  input  wire logic                          wbWe,
  input  wire logic [3:0]                    wbSel,
  input  wire logic [bdm_pkg::WB_ADR_W-1:0]  wbAdr,
  input  wire logic [31:0]                   wbWdat,
  output      logic [31:0]                   wbRdat,
  output      logic                          wbAck,
  // core flag updates into the status register
  input  wire logic [bdm_pkg::DATA_W-1:0]    flagMask,
  input  wire logic [bdm_pkg::DATA_W-1:0]    flagVal,
  // special-function registers that live outside this block
  output      bdm_pkg::bdm_sfr_wr_s          sfrWr,
  output      bdm_pkg::bdm_sfr_rd_s          sfrRd,
  input  wire logic                          sfrHit,
  input  wire logic [bdm_pkg::DATA_W-1:0]    sfrRdata,
  // state seen by the core
  output      logic [bdm_pkg::DATA_W-1:0]    statusOut,
  output      logic [bdm_pkg::DATA_W-1:0]    pointerOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // sizing
  // address map of one bank, by the low seven bits of the effective address:
  //   00h         indirect port, no storage of its own
  //   03h, 04h    status and pointer, answered in both banks
  //   other <20h  special-function registers kept outside this block
  //   20h-7Fh     bank 0 general storage (20h-6Fh on the 80-byte file)
  //   A0h-BFh     bank 1 general storage, 128-byte file only
  //   F0h-FFh     bank 1 common window onto bank 0 70h-7Fh, not on the 80-byte file
  //   anything else reads zero and drops writes

  localparam int unsigned IDX_W = $clog2(GPR_BYTES);
  localparam int unsigned B0_SPAN =
    (GPR_BYTES > bdm_pkg::BANK0_GPR_MAX) ? bdm_pkg::BANK0_GPR_MAX : GPR_BYTES;
  localparam int unsigned B1_SPAN =
    (GPR_BYTES > bdm_pkg::BANK0_GPR_MAX) ? (GPR_BYTES - bdm_pkg::BANK0_GPR_MAX) : 0;
  localparam logic [7:0] B0_SPAN_W = 8'(B0_SPAN);
  // the common window needs bank 0 storage behind 70h-7Fh; the 80-byte file has none
  localparam bit         ALIAS_OK  = COMMON_RAM && (B0_SPAN == bdm_pkg::BANK0_GPR_MAX);
  localparam int unsigned ALIAS_SPAN =
    ALIAS_OK ? (bdm_pkg::BANK0_GPR_MAX + 32'(bdm_pkg::GPR_BASE) - 32'(bdm_pkg::COMMON_LO)) : 0;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [bdm_pkg::DATA_W-1:0] statusQ;
  logic [bdm_pkg::DATA_W-1:0] pointerQ;
  logic                       ackQ;
  logic [bdm_pkg::DATA_W-1:0] rdatQ;
  bdm_pkg::bdm_sfr_wr_s       sfrWrQ;
  logic [bdm_pkg::DATA_W-1:0] memQ [GPR_BYTES];

  ////////////////////////////////////////////////////////////////////////////////
  // request decode

  logic                       reqNew;
  logic                       commit;
  logic [bdm_pkg::OP_W-1:0]   opField;
  logic [bdm_pkg::ADDR_W-1:0] directAddr;
  logic [bdm_pkg::EFF_W-1:0]  indAddr9;
  logic [bdm_pkg::ADDR_W-1:0] effAddr;
  logic                       isIndirect;
  logic                       selfRef;
  logic [bdm_pkg::OP_W-1:0]   lowAddr;
  logic [7:0]                 gprOff;
  logic                       b0Hit;
  logic                       b1Hit;
  logic                       aliasHit;
  logic [IDX_W-1:0]           gprIdx;
  bdm_pkg::bdm_region_e       region;
  logic [bdm_pkg::DATA_W-1:0] readVal;
  logic [bdm_pkg::DATA_W-1:0] wrByte;
  logic                       sfrRdEn;
  logic                       wrStatus;
  logic                       wrPointer;
  logic                       wrGpr;
  logic                       wrSfr;
  logic                       takeRead;
  logic [bdm_pkg::DATA_W-1:0] statusKeep;
  logic [bdm_pkg::DATA_W-1:0] statusPut;

  assign reqNew = wbCyc & wbStb & ~ackQ;
  // writes land at the edge where the master sees ack
  assign commit = wbCyc & wbStb & ackQ & wbWe & wbSel[0];
  assign wrByte = wbWdat[bdm_pkg::DATA_W-1:0];

  assign opField    = wbAdr[bdm_pkg::WB_ADR_LSB +: bdm_pkg::OP_W];
  assign directAddr = {statusQ[bdm_pkg::BANK_SEL_BIT], opField};
  assign isIndirect = (opField == bdm_pkg::INDIRECT_OFS);
  assign indAddr9   = {statusQ[bdm_pkg::IND_BANK_BIT], pointerQ};
  // top bit dropped: the indirect bank bit never reaches the decoder
  assign effAddr    = isIndirect ? indAddr9[bdm_pkg::ADDR_W-1:0] : directAddr;
  assign lowAddr    = effAddr[bdm_pkg::OP_W-1:0];
  // pointer aimed at the indirect port in either bank
  assign selfRef    = isIndirect && (lowAddr == bdm_pkg::INDIRECT_OFS);
  assign gprOff     = {1'b0, lowAddr} - {1'b0, bdm_pkg::GPR_BASE};

  bdm_window_hit #(
    .BANK (1'b0),
    .BASE (bdm_pkg::GPR_BASE),
    .SPAN (B0_SPAN)
  ) u_bank0Win (
    .addr (effAddr),
    .hit  (b0Hit)
  );

  bdm_window_hit #(
    .BANK (1'b1),
    .BASE (bdm_pkg::COMMON_LO),
    .SPAN (ALIAS_SPAN)
  ) u_commonWin (
    .addr (effAddr),
    .hit  (aliasHit)
  );

  // no overlap with the common window: bank 1 storage ends at BFh
  bdm_window_hit #(
    .BANK (1'b1),
    .BASE (bdm_pkg::GPR_BASE),
    .SPAN (B1_SPAN)
  ) u_bank1Win (
    .addr (effAddr),
    .hit  (b1Hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // region and storage index

  always_comb begin
    region = bdm_pkg::REG_NONE;
    gprIdx = '0;
    if (selfRef) begin
      region = bdm_pkg::REG_NONE;
    end else if (lowAddr < bdm_pkg::GPR_BASE) begin
      // status and pointer answer in both banks; the rest go outside
      if (lowAddr == bdm_pkg::STATUS_OFS) begin
        region = bdm_pkg::REG_STATUS;
      end else if (lowAddr == bdm_pkg::POINTER_OFS) begin
        region = bdm_pkg::REG_POINTER;
      end else begin
        region = bdm_pkg::REG_SFR;
      end
    end else if (b0Hit || aliasHit) begin
      region = bdm_pkg::REG_GPR;
      gprIdx = IDX_W'(gprOff);
    end else if (b1Hit) begin
      region = bdm_pkg::REG_GPR;
      gprIdx = IDX_W'(gprOff + B0_SPAN_W);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    readVal = bdm_pkg::ZERO_BYTE;
    unique case (region)
      bdm_pkg::REG_NONE: begin
        readVal = bdm_pkg::ZERO_BYTE;
      end
      bdm_pkg::REG_STATUS: begin
        readVal = statusQ;
      end
      bdm_pkg::REG_POINTER: begin
        readVal = pointerQ;
      end
      bdm_pkg::REG_SFR: begin
        // a location nobody claims reads as zero
        readVal = sfrHit ? sfrRdata : bdm_pkg::ZERO_BYTE;
      end
      bdm_pkg::REG_GPR: begin
        readVal = memQ[gprIdx];
      end
      default: begin
        readVal = bdm_pkg::ZERO_BYTE;
      end
    endcase
  end

  // outside registers see the read enable only on the first request cycle
  assign sfrRdEn = reqNew & ~wbWe & (region == bdm_pkg::REG_SFR);
  assign sfrRd   = '{addr: effAddr, en: sfrRdEn};

  ////////////////////////////////////////////////////////////////////////////////
  // write and read enables, one per target

  // every write target is gated by commit, so a dropped byte lane stores nothing
  assign wrStatus  = commit && (region == bdm_pkg::REG_STATUS);
  assign wrPointer = commit && (region == bdm_pkg::REG_POINTER);
  assign wrGpr     = commit && (region == bdm_pkg::REG_GPR);
  // a self-referencing indirect write decodes to no region: nothing is written
  assign wrSfr     = commit && (region == bdm_pkg::REG_SFR);
  assign takeRead  = reqNew && !wbWe;

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone handshake

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
    end else begin
      // one-cycle ack, dropped the cycle after it was given
      ackQ <= reqNew;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdatQ <= bdm_pkg::ZERO_BYTE;
    end else if (takeRead) begin
      rdatQ <= readVal;
    end
  end

  assign wbAck  = ackQ;
  assign wbRdat = {24'h000000, rdatQ};

  ////////////////////////////////////////////////////////////////////////////////
  // status register

  bdm_flag_merge #(
    .WIDTH (bdm_pkg::DATA_W)
  ) u_statusKeep (
    .base   (statusQ),
    .mask   (flagMask),
    .flags  (flagVal),
    .merged (statusKeep)
  );

  // core flags win over a software write on the masked bits
  bdm_flag_merge #(
    .WIDTH (bdm_pkg::DATA_W)
  ) u_statusPut (
    .base   (wrByte),
    .mask   (flagMask),
    .flags  (flagVal),
    .merged (statusPut)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusQ <= bdm_pkg::STATUS_RST;
    end else if (wrStatus) begin
      statusQ <= statusPut;
    end else begin
      statusQ <= statusKeep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pointer register

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pointerQ <= bdm_pkg::POINTER_RST;
    end else if (wrPointer) begin
      pointerQ <= wrByte;
    end
  end

  assign statusOut  = statusQ;
  assign pointerOut = pointerQ;

  ////////////////////////////////////////////////////////////////////////////////
  // general-purpose storage

  // no reset: contents are undefined at power-up, as for any static RAM
  always_ff @(posedge ref_clk) begin
    if (wrGpr) begin
      memQ[gprIdx] <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outside special-function writes

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrWrQ <= '0;
    end else if (wrSfr) begin
      sfrWrQ.addr   <= effAddr;
      sfrWrQ.data   <= wrByte;
      sfrWrQ.strobe <= 1'b1;
    end else begin
      // a self-referencing indirect write lands here: strobe stays low
      sfrWrQ.strobe <= 1'b0;
    end
  end

  assign sfrWr = sfrWrQ;

endmodule : bdm_data_memory

////////////////////////////////////////////////////////////////////////////////
// one general-purpose window of one bank, matched on the effective address

module bdm_window_hit #(
  parameter bit                       BANK = 1'b0,
  parameter logic [bdm_pkg::OP_W-1:0] BASE = bdm_pkg::GPR_BASE,
  parameter int unsigned              SPAN = bdm_pkg::BANK0_GPR_MAX
) (
  input  wire logic [bdm_pkg::ADDR_W-1:0] addr,
  output      logic                       hit
);

  localparam logic [7:0] SPAN_W = 8'(SPAN);

  logic [7:0] offset;

  // the offset wraps below the base, so the lower bound is tested on its own
  assign offset = {1'b0, addr[bdm_pkg::OP_W-1:0]} - {1'b0, BASE};
  assign hit    = (addr[bdm_pkg::ADDR_W-1] == BANK) && (addr[bdm_pkg::OP_W-1:0] >= BASE)
                  && (offset < SPAN_W);

endmodule : bdm_window_hit

////////////////////////////////////////////////////////////////////////////////
// masked merge: bits under the mask take the core's flags, the rest keep base

module bdm_flag_merge #(
  parameter int unsigned WIDTH = bdm_pkg::DATA_W
) (
  input  wire logic [WIDTH-1:0] base,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [WIDTH-1:0] flags,
  output      logic [WIDTH-1:0] merged
);

  assign merged = (base & ~mask) | (flags & mask);

endmodule : bdm_flag_merge

// ### verif/bdm_sva.sv
`timescale 1ns/10ps
module bdm_sva (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 wbCyc,
  input wire logic                 wbStb,
  input wire logic                 wbWe,
  input wire logic [3:0]           wbSel,
  input wire logic [8:0]           wbAdr,
  input wire logic [31:0]          wbWdat,
  input wire logic [31:0]          wbRdat,
  input wire logic                 wbAck,
  input wire logic [7:0]           flagMask,
  input wire bdm_pkg::bdm_sfr_wr_s sfrWr,
  input wire bdm_pkg::bdm_sfr_rd_s sfrRd,
  input wire logic [7:0]           statusOut,
  input wire logic [7:0]           pointerOut
);
  logic       req;
  logic [6:0] idx;
  assign req = wbCyc && wbStb && !wbAck;
  assign idx = wbAdr[8:2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  property p_ack; req |=> wbAck ##1 !wbAck; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_hi; wbAck |-> wbRdat[31:8] == 24'h0 && $past(wbCyc && wbStb); endproperty
  a_hi: assert property (p_hi) else $error("bad ack or upper lanes");
  property p_ptr;
    wbAck && wbWe && wbSel[0] && idx == bdm_pkg::POINTER_OFS |=>
      pointerOut == $past(wbWdat[7:0]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write lost");
  property p_hold; !(wbAck && wbWe) |=> $stable(pointerOut); endproperty
  a_hold: assert property (p_hold) else $error("pointer changed");
  property p_selfRd; req && !wbWe && idx == 7'h0 && pointerOut[6:0] == 7'h0 |=>
    wbRdat[7:0] == 8'h00; endproperty
  a_selfRd: assert property (p_selfRd) else $error("self read not zero");
  property p_selfWr; wbAck && wbWe && idx == 7'h0 && pointerOut[6:0] == 7'h0 &&
    flagMask == 8'h0 |=> $stable(pointerOut) && $stable(statusOut); endproperty
  a_selfWr: assert property (p_selfWr) else $error("self write stored");
  property p_selfQuiet; wbAck && wbWe && idx == 7'h0 && pointerOut[6:0] == 7'h0 |=>
    !sfrWr.strobe; endproperty
  a_selfQuiet: assert property (p_selfQuiet) else $error("self write went outside");
  property p_dir; sfrRd.en && idx != 7'h0 |-> sfrRd.addr == {statusOut[5], idx};
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_ind; sfrRd.en && idx == 7'h0 |-> sfrRd.addr == pointerOut; endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");
  property p_sfrWr; sfrWr.strobe |-> $past(wbAck && wbWe && wbSel[0]) &&
    sfrWr.data == $past(wbWdat[7:0]); endproperty
  a_sfrWr: assert property (p_sfrWr) else $error("outside write wrong");
  c_selfRd: cover property (req && idx == 7'h0 && pointerOut[6:0] == 7'h0);
  c_bank1: cover property (sfrRd.en && statusOut[5]);
  c_sfrWr: cover property (sfrWr.strobe);
endmodule : bdm_sva

// ### verif/bdm_sfr_model.sv
`timescale 1ns/10ps
module bdm_sfr_model (
  input  wire logic                 ref_clk,
  input  wire bdm_pkg::bdm_sfr_wr_s sfrWr,
  input  wire bdm_pkg::bdm_sfr_rd_s sfrRd,
  output      logic                 sfrHit,
  output      logic [7:0]           sfrRdata
);
  logic [7:0] mem [256];
  // 07h of each bank is left empty so the zero path gets used
  assign sfrHit = sfrRd.en && sfrRd.addr[6:0] != 7'h07;
  // idle data is inverted so a stale value never looks right
  assign sfrRdata = sfrRd.en ? mem[sfrRd.addr] : ~mem[sfrRd.addr];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  always @(posedge ref_clk) if (sfrWr.strobe) mem[sfrWr.addr] <= sfrWr.data;
endmodule : bdm_sfr_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                 ref_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, sfrHit;
  logic [3:0]           wbSel;
  logic [8:0]           wbAdr;
  logic [31:0]          wbWdat, wbRdat;
  logic [7:0]           flagMask, flagVal, sfrRdata, statusOut, pointerOut, q;
  bdm_pkg::bdm_sfr_wr_s sfrWr;
  bdm_pkg::bdm_sfr_rd_s sfrRd;
  int                   err_count = 0;
  int                   checked = 0;
  bdm_data_memory #(.GPR_BYTES(96), .COMMON_RAM(1'b1)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbSel(wbSel), .wbAdr(wbAdr), .wbWdat(wbWdat), .wbRdat(wbRdat), .wbAck(wbAck),
    .flagMask(flagMask), .flagVal(flagVal), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrHit(sfrHit), .sfrRdata(sfrRdata), .statusOut(statusOut), .pointerOut(pointerOut)
  );
  bdm_sfr_model u_sfr (
    .ref_clk(ref_clk), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrHit(sfrHit), .sfrRdata(sfrRdata)
  );
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {i, 2'b00};
    wbWdat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbRdat[7:0];
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), e, q);
  endtask : rd
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbWdat, flagMask, flagVal} = '0;
    wbSel = 4'h1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("status", 8'h00, statusOut);
    chk("pointer", 8'h00, pointerOut);
    $display("test reset done");
    wb(1'b1, 7'h20, 8'ha5);
    wb(1'b1, 7'h6f, 8'h5a);
    wb(1'b1, 7'h75, 8'h3c);
    wb(1'b1, 7'h05, 8'h3c);
    wbSel <= 4'h0;
    wb(1'b1, 7'h20, 8'hff);
    wbSel <= 4'h1;
    rd(7'h20, 8'ha5);
    rd(7'h6f, 8'h5a);
    wb(1'b1, 7'h03, 8'h20);
    chk("status", 8'h20, statusOut);
    rd(7'h75, 8'h3c);
    wb(1'b1, 7'h7e, 8'h81);
    wb(1'b1, 7'h20, 8'h99);
    rd(7'h20, 8'h00);
    wb(1'b1, 7'h05, 8'hc3);
    rd(7'h05, 8'hc3);
    wb(1'b1, 7'h03, 8'h00);
    rd(7'h7e, 8'h81);
    rd(7'h20, 8'ha5);
    rd(7'h05, 8'h3c);
    wb(1'b1, 7'h07, 8'h77);
    rd(7'h07, 8'h00);
    $display("test direct done");
    wb(1'b1, 7'h04, 8'hfe);
    chk("pointer", 8'hfe, pointerOut);
    rd(7'h00, 8'h81);
    wb(1'b1, 7'h04, 8'h85);
    rd(7'h00, 8'hc3);
    wb(1'b1, 7'h04, 8'h20);
    wb(1'b1, 7'h03, 8'h80);
    wb(1'b1, 7'h00, 8'h11);
    rd(7'h20, 8'h11);
    wb(1'b1, 7'h04, 8'h80);
    rd(7'h00, 8'h00);
    wb(1'b1, 7'h04, 8'h00);
    wb(1'b1, 7'h00, 8'h44);
    chk("pointer", 8'h00, pointerOut);
    chk("status", 8'h80, statusOut);
    rd(7'h00, 8'h00);
    $display("test indirect done");
    flagMask <= 8'h01;
    flagVal <= 8'h01;
    @(posedge ref_clk);
    flagMask <= 8'h00;
    @(posedge ref_clk);
    chk("flags", 8'h81, statusOut);
    flagMask <= 8'h01;
    flagVal <= 8'h00;
    wb(1'b1, 7'h03, 8'h21);
    flagMask <= 8'h00;
    chk("flags", 8'h20, statusOut);
    $display("test flags done");
    conclude();
  end
endmodule : testbench
bind bdm_data_memory bdm_sva u_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbSel(wbSel), .wbAdr(wbAdr), .wbWdat(wbWdat), .wbRdat(wbRdat), .wbAck(wbAck),
  .flagMask(flagMask), .sfrWr(sfrWr), .sfrRd(sfrRd), .statusOut(statusOut),
  .pointerOut(pointerOut)
);
